// ### logic/twm_pkg.sv
package twm_pkg;
    // ======================================================
    // Widths
    localparam int CNT_W = 10;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int NCH = 3;
    localparam int NPIN = 6;
    // ======================================================
    // Register offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_COM = 4'h1;
    localparam logic [3:0] ADDR_CMP_A = 4'h2;
    localparam logic [3:0] ADDR_CMP_B = 4'h3;
    localparam logic [3:0] ADDR_CMP_D = 4'h4;
    localparam logic [3:0] ADDR_TOP = 4'h5;
    localparam logic [3:0] ADDR_COUNT = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    localparam logic [3:0] ADDR_PORT = 4'h8;
    localparam logic [3:0] ADDR_DDR = 4'h9;
    localparam logic [3:0] ADDR_PINS = 4'hA;
    // ======================================================
    // Field positions
    localparam int CTRL_PWM_LSB = 0;
    localparam int CTRL_MODE_LSB = 3;
    localparam int STAT_OVF = 0;
    localparam int STAT_DIR = 1;
    // ======================================================
    // Encodings and reset values
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOG = 2'h1;
    localparam logic [1:0] COM_CLR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    localparam logic [1:0] WMODE_FAST = 2'h0;
    localparam logic [1:0] WMODE_DUAL = 2'h1;
    localparam logic [CNT_W-1:0] TOP_RST = 10'h3FF;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;

    typedef enum logic [2:0] {
        TWM_NORMAL = 3'b001,
        TWM_FAST = 3'b010,
        TWM_DUAL = 3'b100
    } twm_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } twm_bus_req_t;

    typedef struct packed {
        logic [NPIN-1:0] dout;
        logic [NPIN-1:0] oe;
    } twm_pins_t;
endpackage

// ### logic/twm_core.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
// Operation
// - Normal mode counts zero to top, wraps
// - Normal overflow flag set when count wraps
// - Overflow service acknowledge clears the flag
// - Counter writable at any time
// - Normal mode 1 toggles output on match
// - Normal mode drives only complementary pin
// - Pin shows compare value only when output
// - Fast PWM when enabled and field 00
// - Fast PWM clears on match, sets at wrap
// - PWM modes: 2 normal, 3 inverted, 1 pair
// - Fast PWM overflow flag set at top
// - Fast PWM extreme top values handled
// - Fast PWM mode 1 drives pin pair
// - Mode 0 leaves port value on pins
// - Dual-slope when enabled and field 01
// - Dual-slope clears up-match, sets down-match
// - Dual-slope holds top one tick, reverses
// - Dual-slope overflow flag set at zero
// - Dual-slope extreme top gives constant levels
// - Dual complementary clears match, sets zero
// - Mode bit change acts on waveform at next match, on pin override at once
// - Pin output lags waveform one tick
module twm_core (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic timer_tick_i,
    input wire logic ovf_ack_i,
    input wire twm_pkg::twm_bus_req_t bus_i,
    output logic [twm_pkg::DATA_W-1:0] rdata_o,
    output logic overflow_flag_o,
    output logic [twm_pkg::CNT_W-1:0] count_value_o,
    output logic [twm_pkg::NCH-1:0] waveform_out_o,
    output twm_pkg::twm_pins_t pins_o
);

    typedef struct packed {
        logic [twm_pkg::CNT_W-1:0] cnt;
        logic dir_dn;
        logic ovf;
        logic [twm_pkg::CNT_W-1:0] spike;
        logic [twm_pkg::NCH-1:0] pwm_en;
        logic [1:0] wmode;
        logic [twm_pkg::NCH-1:0][1:0] com;
        logic [twm_pkg::NCH-1:0][1:0] com_act;
        logic [twm_pkg::NCH-1:0][twm_pkg::CNT_W-1:0] ocr;
        logic [twm_pkg::CNT_W-1:0] top;
        logic [twm_pkg::NPIN-1:0] port;
        logic [twm_pkg::NPIN-1:0] ddr;
        logic [twm_pkg::NCH-1:0] wave;
        logic [twm_pkg::NCH-1:0] oc;
        twm_pkg::twm_pins_t pins;
        logic [twm_pkg::DATA_W-1:0] rdata;
    } twm_state_t;

    twm_state_t s_reg;
    twm_state_t s_next;

    // ======================================================
    // Helpers
    function automatic twm_pkg::twm_mode_t cnt_mode(
        input logic any_pwm,
        input logic [1:0] wm
    );
        twm_pkg::twm_mode_t m;
        m = twm_pkg::TWM_NORMAL;
        if (any_pwm) begin
            if (wm == twm_pkg::WMODE_DUAL) begin
                m = twm_pkg::TWM_DUAL;
            end else begin
                m = twm_pkg::TWM_FAST;
            end
        end
        return m;
    endfunction

    // Next waveform level for one channel
    function automatic logic wave_step(
        input twm_pkg::twm_mode_t m,
        input logic [1:0] com,
        input logic w,
        input logic hit,
        input logic bottom,
        input logic dn,
        input logic tz,
        input logic tm,
        input logic spk
    );
        logic r;
        logic inv;
        r = w;
        inv = (com == twm_pkg::COM_SET);
        unique case (m)
            twm_pkg::TWM_NORMAL: begin
                if (hit) begin
                    unique case (com)
                        twm_pkg::COM_TOG: r = ~w;
                        twm_pkg::COM_CLR: r = 1'b0;
                        twm_pkg::COM_SET: r = 1'b1;
                        default: r = w;
                    endcase
                end
            end
            twm_pkg::TWM_FAST: begin
                if (com != twm_pkg::COM_OFF) begin
                    if (tm) begin
                        r = ~inv;
                    end else if (tz) begin
                        r = spk ^ inv;
                    end else if (bottom) begin
                        r = ~inv;
                    end else if (hit) begin
                        r = inv;
                    end
                end
            end
            twm_pkg::TWM_DUAL: begin
                if (com != twm_pkg::COM_OFF) begin
                    if (tz) begin
                        r = inv;
                    end else if (tm) begin
                        r = ~inv;
                    end else if (com == twm_pkg::COM_TOG) begin
                        if (bottom) begin
                            r = 1'b1;
                        end else if (hit) begin
                            r = 1'b0;
                        end
                    end else if (hit) begin
                        r = dn ^ inv;
                    end
                end
            end
            default: r = w;
        endcase
        return r;
    endfunction

    // ======================================================
    // Next-state logic
    twm_pkg::twm_mode_t mode;
    logic [twm_pkg::CNT_W-1:0] cnt_n;
    logic dir_n;
    logic at_top;
    logic wrap;
    logic bottom;
    logic ovf_set;
    logic ovf_clr;
    logic tz;
    logic tm;
    logic [twm_pkg::NCH-1:0] hit;
    logic [1:0] com_eff;
    logic [twm_pkg::DATA_W-1:0] wd;
    logic wr;
    logic [1:0] cm;
    logic pwm_ch;
    logic pair;

    always_comb begin
        s_next = s_reg;
        mode = cnt_mode(|s_reg.pwm_en, s_reg.wmode);
        cnt_n = s_reg.cnt;
        dir_n = s_reg.dir_dn;
        at_top = (s_reg.cnt == s_reg.top);
        tz = (s_reg.top == '0);
        tm = (s_reg.top == twm_pkg::CNT_MAX);
        wrap = 1'b0;
        bottom = 1'b0;
        ovf_set = 1'b0;
        ovf_clr = 1'b0;
        hit = '0;
        com_eff = twm_pkg::COM_OFF;
        wd = bus_i.wdata;
        wr = bus_i.wr;
        cm = twm_pkg::COM_OFF;
        pwm_ch = 1'b0;
        pair = 1'b0;
        if (clk_en_i) begin
            if (timer_tick_i) begin
                unique case (mode)
                    twm_pkg::TWM_DUAL: begin
                        if (tz) begin
                            cnt_n = '0;
                            dir_n = 1'b0;
                        end else if (!s_reg.dir_dn) begin
                            if (s_reg.cnt >= s_reg.top) begin
                                // One tick at top, then down
                                cnt_n = s_reg.top - 1'b1;
                                dir_n = 1'b1;
                            end else begin
                                cnt_n = s_reg.cnt + 1'b1;
                            end
                        end else if (s_reg.cnt == '0) begin
                            cnt_n = {{(twm_pkg::CNT_W-1){1'b0}}, 1'b1};
                            dir_n = 1'b0;
                        end else begin
                            cnt_n = s_reg.cnt - 1'b1;
                        end
                        bottom = (s_reg.cnt == '0);
                        ovf_set = (cnt_n == '0);
                    end
                    twm_pkg::TWM_FAST: begin
                        cnt_n = at_top ? '0 : s_reg.cnt + 1'b1;
                        wrap = at_top;
                        ovf_set = (cnt_n == s_reg.top);
                    end
                    default: begin
                        cnt_n = at_top ? '0 : s_reg.cnt + 1'b1;
                        wrap = at_top;
                        ovf_set = at_top;
                    end
                endcase
                if (mode != twm_pkg::TWM_DUAL) begin
                    bottom = wrap;
                end
                s_next.cnt = cnt_n;
                s_next.dir_dn = dir_n;
                s_next.spike = s_reg.spike + 1'b1;
                for (int c = 0; c < twm_pkg::NCH; c++) begin
                    hit[c] = (s_reg.cnt == s_reg.ocr[c]);
                    // New mode bits latch only on a match
                    com_eff = hit[c] ? s_reg.com[c] : s_reg.com_act[c];
                    s_next.com_act[c] = com_eff;
                    s_next.wave[c] = wave_step(
                        s_reg.pwm_en[c] ? mode : twm_pkg::TWM_NORMAL,
                        com_eff, s_reg.wave[c], hit[c], bottom,
                        s_reg.dir_dn, tz, tm, (s_reg.spike == '0));
                end
                // Pin stage is the old waveform, one tick late
                s_next.oc = s_reg.wave;
            end
            ovf_clr = ovf_ack_i;
            if (wr && bus_i.addr == twm_pkg::ADDR_STATUS) begin
                ovf_clr = ovf_clr | wd[twm_pkg::STAT_OVF];
            end
            // Set beats a same-cycle clear
            s_next.ovf = ovf_set | (s_reg.ovf & ~ovf_clr);
            if (wr) begin
                unique case (bus_i.addr)
                    twm_pkg::ADDR_CTRL: begin
                        s_next.pwm_en = wd[twm_pkg::CTRL_PWM_LSB +: twm_pkg::NCH];
                        s_next.wmode = wd[twm_pkg::CTRL_MODE_LSB +: 2];
                    end
                    twm_pkg::ADDR_COM: s_next.com = wd[2*twm_pkg::NCH-1:0];
                    twm_pkg::ADDR_CMP_A: s_next.ocr[0] = wd[twm_pkg::CNT_W-1:0];
                    twm_pkg::ADDR_CMP_B: s_next.ocr[1] = wd[twm_pkg::CNT_W-1:0];
                    twm_pkg::ADDR_CMP_D: s_next.ocr[2] = wd[twm_pkg::CNT_W-1:0];
                    twm_pkg::ADDR_TOP: s_next.top = wd[twm_pkg::CNT_W-1:0];
                    twm_pkg::ADDR_COUNT: s_next.cnt = wd[twm_pkg::CNT_W-1:0];
                    twm_pkg::ADDR_PORT: s_next.port = wd[twm_pkg::NPIN-1:0];
                    twm_pkg::ADDR_DDR: s_next.ddr = wd[twm_pkg::NPIN-1:0];
                    default: begin
                    end
                endcase
            end
            s_next.rdata = '0;
            if (bus_i.rd) begin
                unique case (bus_i.addr)
                    twm_pkg::ADDR_CTRL: begin
                        s_next.rdata[twm_pkg::CTRL_PWM_LSB +: twm_pkg::NCH] = s_reg.pwm_en;
                        s_next.rdata[twm_pkg::CTRL_MODE_LSB +: 2] = s_reg.wmode;
                    end
                    twm_pkg::ADDR_COM: s_next.rdata[2*twm_pkg::NCH-1:0] = s_reg.com;
                    twm_pkg::ADDR_CMP_A: s_next.rdata[twm_pkg::CNT_W-1:0] = s_reg.ocr[0];
                    twm_pkg::ADDR_CMP_B: s_next.rdata[twm_pkg::CNT_W-1:0] = s_reg.ocr[1];
                    twm_pkg::ADDR_CMP_D: s_next.rdata[twm_pkg::CNT_W-1:0] = s_reg.ocr[2];
                    twm_pkg::ADDR_TOP: s_next.rdata[twm_pkg::CNT_W-1:0] = s_reg.top;
                    twm_pkg::ADDR_COUNT: s_next.rdata[twm_pkg::CNT_W-1:0] = s_reg.cnt;
                    twm_pkg::ADDR_STATUS: begin
                        s_next.rdata[twm_pkg::STAT_OVF] = s_reg.ovf;
                        s_next.rdata[twm_pkg::STAT_DIR] = s_reg.dir_dn;
                    end
                    twm_pkg::ADDR_PORT: s_next.rdata[twm_pkg::NPIN-1:0] = s_reg.port;
                    twm_pkg::ADDR_DDR: s_next.rdata[twm_pkg::NPIN-1:0] = s_reg.ddr;
                    twm_pkg::ADDR_PINS: s_next.rdata[twm_pkg::NPIN-1:0] = s_reg.pins.dout;
                    default: s_next.rdata = '0;
                endcase
            end
            // Pin override follows mode bits at once
            for (int c = 0; c < twm_pkg::NCH; c++) begin
                cm = s_next.com[c];
                pwm_ch = s_next.pwm_en[c];
                pair = pwm_ch && (cm == twm_pkg::COM_TOG);
                // Positive pin only used by the pair setting
                s_next.pins.dout[2*c] = pair ? s_next.oc[c] : s_next.port[2*c];
                if (cm == twm_pkg::COM_OFF) begin
                    s_next.pins.dout[2*c+1] = s_next.port[2*c+1];
                end else if (pair) begin
                    s_next.pins.dout[2*c+1] = ~s_next.oc[c];
                end else begin
                    s_next.pins.dout[2*c+1] = s_next.oc[c];
                end
            end
            s_next.pins.oe = s_next.ddr;
        end
    end

    // ======================================================
    // State register
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_reg <= '0;
            s_reg.top <= twm_pkg::TOP_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ======================================================
    // Outputs
    assign rdata_o = s_reg.rdata;
    assign overflow_flag_o = s_reg.ovf;
    assign count_value_o = s_reg.cnt;
    assign waveform_out_o = s_reg.wave;
    assign pins_o = s_reg.pins;

endmodule

// ### bench/twm_core_props.sv
`timescale 1ns/10ps
// ==========================================
// Port checks
module twm_core_props (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic timer_tick_i,
    input wire logic ovf_ack_i,
    input wire twm_pkg::twm_bus_req_t bus_i,
    input wire logic [twm_pkg::DATA_W-1:0] rdata_o,
    input wire logic overflow_flag_o,
    input wire logic [twm_pkg::CNT_W-1:0] count_value_o,
    input wire logic [twm_pkg::NCH-1:0] waveform_out_o,
    input wire twm_pkg::twm_pins_t pins_o
);
    logic tk;
    logic cwr;
    logic swr;
    logic dwr;
    logic crd;
    logic [twm_pkg::CNT_W-1:0] wd;
    logic [twm_pkg::NPIN-1:0] oe;
    assign tk = clk_en_i & timer_tick_i;
    assign cwr = clk_en_i & bus_i.wr & (bus_i.addr == twm_pkg::ADDR_COUNT);
    assign swr = clk_en_i & bus_i.wr & (bus_i.addr == twm_pkg::ADDR_STATUS) & bus_i.wdata[0];
    assign dwr = clk_en_i & bus_i.wr & (bus_i.addr == twm_pkg::ADDR_DDR);
    assign crd = clk_en_i & bus_i.rd & (bus_i.addr == twm_pkg::ADDR_COUNT);
    assign wd = bus_i.wdata[twm_pkg::CNT_W-1:0];
    assign oe = pins_o.oe;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    a_count_frozen: assert property (!tk && !cwr |=> $stable(count_value_o))
        else $error("count moved without a tick");
    a_count_step: assert property (tk && !cwr |=> count_value_o == 10'h000 ||
        count_value_o - $past(count_value_o) == 10'h001 ||
        $past(count_value_o) - count_value_o == 10'h001)
        else $error("count jumped on a tick");
    a_count_load: assert property (cwr |=> count_value_o == $past(wd))
        else $error("count write not loaded");
    a_count_read: assert property (crd |=> rdata_o == {6'h00, $past(count_value_o)})
        else $error("count read wrong");
    a_ovf_on_tick: assert property ($rose(overflow_flag_o) |-> $past(tk))
        else $error("flag set without a tick");
    a_ovf_sticky: assert property (overflow_flag_o && !ovf_ack_i && !swr |=> overflow_flag_o)
        else $error("flag cleared by counting");
    a_ovf_ack_clear: assert property (overflow_flag_o && ovf_ack_i && clk_en_i && !tk
        |=> !overflow_flag_o)
        else $error("flag kept after service");
    a_oe_from_ddr: assert property ($changed(oe) |-> $past(dwr) || $past(dwr, 2))
        else $error("direction moved without write");
    a_wave_on_tick: assert property (!tk |=> $stable(waveform_out_o))
        else $error("waveform moved without a tick");
endmodule

bind twm_core twm_core_props u_props (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .timer_tick_i(timer_tick_i), .ovf_ack_i(ovf_ack_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .overflow_flag_o(overflow_flag_o), .count_value_o(count_value_o),
    .waveform_out_o(waveform_out_o), .pins_o(pins_o)
);

// ### bench/twm_load.sv
`timescale 1ns/10ps
// ==========================================
// Switch load on the pins
module twm_load (
    input wire logic core_clk_i,
    input wire twm_pkg::twm_pins_t pins_i,
    output logic [twm_pkg::NPIN-1:0] level_o
);
    logic [twm_pkg::NPIN-1:0] last_reg;
    always_ff @(posedge core_clk_i) begin
        last_reg <= level_o;
    end
    // No pull fitted: a released pin wanders, so it must never read as the old level
    always_comb begin
        for (int i = 0; i < twm_pkg::NPIN; i++) begin
            level_o[i] = pins_i.oe[i] ? pins_i.dout[i] : ~last_reg[i];
        end
    end
endmodule

// ### bench/timer_waveform_modes_tb_top.sv
`timescale 1ns/10ps
module timer_waveform_modes_tb_top;
    logic core_clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic clk_en_i = 1'h1;
    logic timer_tick_i = 1'h1;
    logic ovf_ack_i = 1'h0;
    twm_pkg::twm_bus_req_t bus_i = '0;
    logic [15:0] rdata_o;
    logic overflow_flag_o;
    logic [9:0] count_value_o;
    logic [2:0] waveform_out_o;
    twm_pkg::twm_pins_t pins_o;
    logic [5:0] level;
    int err_count = 0;
    int num_checks = 0;
    logic [9:0] c;
    logic ws;
    logic p;
    logic [15:0] xc [3] = '{16'h0009, 16'h0009, 16'h0001};
    logic [15:0] xt [3] = '{16'h0000, 16'h0000, 16'h03FF};
    logic [15:0] xm [3] = '{16'h0002, 16'h0003, 16'h0002};
    logic xw [3] = '{1'h0, 1'h1, 1'h1};

    twm_core dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .timer_tick_i(timer_tick_i), .ovf_ack_i(ovf_ack_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .overflow_flag_o(overflow_flag_o), .count_value_o(count_value_o),
        .waveform_out_o(waveform_out_o), .pins_o(pins_o));
    twm_load load (.core_clk_i(core_clk_i), .pins_i(pins_o), .level_o(level));

    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end

    // ==========================================
    // Bus and check tasks
    task automatic close_out();
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // Gap edge after each strobe keeps one assignment per signal per time step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus_i.addr <= a;
        bus_i.wdata <= d;
        bus_i.wr <= 1'h1;
        cyc(1);
        bus_i.wr <= 1'h0;
        cyc(1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        bus_i.addr <= a;
        bus_i.rd <= 1'h1;
        cyc(1);
        chk(rdata_o, e);
        bus_i.rd <= 1'h0;
        cyc(1);
    endtask
    task automatic sync0();
        cyc(8);
        for (int n = 0; n < 2100; n++) begin
            if (count_value_o === 10'h000) return;
            cyc(1);
        end
        err_count++;
        close_out();
    endtask

    // ==========================================
    // Scenarios
    initial begin
        cyc(6);
        sys_rst_i <= 1'h0;
        cyc(1);
        rd(twm_pkg::ADDR_TOP, 16'h03FF);
        rd(4'hF, 16'h0000);
        wr(twm_pkg::ADDR_CMP_B, 16'h02AA);
        wr(twm_pkg::ADDR_CMP_D, 16'h0155);
        rd(twm_pkg::ADDR_CMP_B, 16'h02AA);
        rd(twm_pkg::ADDR_CMP_D, 16'h0155);
        wr(twm_pkg::ADDR_DDR, 16'h003F);
        wr(twm_pkg::ADDR_PORT, 16'h0015);
        chk(pins_o.dout, 6'h15);
        chk(level, 6'h15);
        wr(twm_pkg::ADDR_TOP, 16'h0003);
        wr(twm_pkg::ADDR_CMP_A, 16'h0002);
        wr(twm_pkg::ADDR_COM, 16'h0001);
        wr(twm_pkg::ADDR_COUNT, 16'h0000);
        wr(twm_pkg::ADDR_STATUS, 16'h0001);
        chk(count_value_o, 10'h003);
        chk(overflow_flag_o, 1'h0);
        cyc(1);
        chk(overflow_flag_o, 1'h1);
        ws = waveform_out_o[0];
        for (int i = 1; i < 9; i++) begin
            p = waveform_out_o[0];
            cyc(1);
            chk(count_value_o, 10'(i % 4));
            chk(pins_o.dout[1:0], {p, 1'h1});
            if (i % 4 == 0) chk(waveform_out_o[0], ws ^ (i == 4));
        end
        // Service with no tick, so no same-cycle set can mask the clear
        timer_tick_i <= 1'h0;
        ovf_ack_i <= 1'h1;
        cyc(1);
        ovf_ack_i <= 1'h0;
        chk(overflow_flag_o, 1'h0);
        timer_tick_i <= 1'h1;
        clk_en_i <= 1'h0;
        cyc(3);
        clk_en_i <= 1'h1;
        timer_tick_i <= 1'h0;
        cyc(3);
        chk(count_value_o, 10'h000);
        timer_tick_i <= 1'h1;
        rd(twm_pkg::ADDR_COUNT, 16'h0000);
        wr(twm_pkg::ADDR_CMP_A, 16'h0001);
        for (int d = 0; d < 2; d++) begin
            wr(twm_pkg::ADDR_CTRL, d ? 16'h0009 : 16'h0001);
            for (int m = 1; m < 4; m++) begin
                wr(twm_pkg::ADDR_COM, 16'(m));
                sync0();
                for (int i = 0; i < 6; i++) begin
                    c = d ? 10'(i < 4 ? i : 6 - i) : 10'(i % 4);
                    ovf_ack_i <= (i == 1);
                    chk(count_value_o, c);
                    // Complementary dual: the down match clears before bottom sets
                    p = d && (i > 3 || (i == 0 && m == 1));
                    chk(waveform_out_o[0], (c < 2 && !p) ^ (m == 3));
                    chk(m == 1 ? pins_o.dout[0] ^ pins_o.dout[1] : pins_o.dout[0], 1'h1);
                    if (i > 1) chk(overflow_flag_o, i > 2 && !d);
                    cyc(1);
                end
                chk(overflow_flag_o, 1'h1);
            end
        end
        wr(twm_pkg::ADDR_CMP_A, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            // Mode bits latch only on a match, so set them before top moves
            wr(twm_pkg::ADDR_CTRL, xc[k]);
            wr(twm_pkg::ADDR_COM, xm[k]);
            wr(twm_pkg::ADDR_TOP, xt[k]);
            sync0();
            repeat (8) begin
                chk(waveform_out_o[0], xw[k]);
                cyc(1);
            end
        end
        close_out();
    end
endmodule
